/* File: common/spdbf_pkg.sv */
// Purpose: shared constants and types of the serial port dma buffer fifo
// Assumes: 32-bit register words, byte addresses on an 8-bit address port
// Notes: count field width default lives here, the module may narrow it
package spdbf_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam logic [7:0] OFF_TX_CTRL = 8'h00;
    localparam logic [7:0] OFF_RX_CTRL = 8'h04;
    localparam logic [7:0] OFF_TX_DATA = 8'h08;
    localparam logic [7:0] OFF_RX_DATA = 8'h0c;
    localparam logic [7:0] OFF_STATUS = 8'h10;
    localparam int unsigned EN_BIT = 0;
    localparam int unsigned BURST_LSB = 8;
    localparam int unsigned EVT_LSB = 16;
    localparam int unsigned STAT_RX_LSB = 16;
    localparam int unsigned CNT_W_DEF = 8;
    localparam int unsigned DEPTH_DEF = 16;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } spdbf_bus_t;
endpackage

/* File: src/spdbf_buffer_fifo.sv */
// Purpose: transmit and receive buffer fifos between a serial port core and host dma
// Assumes: core requests are one-cycle pulses on clk; host dma reaches data via the reg port
// Notes: a disabled fifo is flushed and its direction passes straight through
//
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none

module spdbf_buffer_fifo #(
    parameter int unsigned DEPTH = spdbf_pkg::DEPTH_DEF,
    parameter int unsigned CNT_W = spdbf_pkg::CNT_W_DEF
) (
    input wire logic clk,                       // clock, 250 MHz
    input wire logic rst,                       // async reset, active high
    input wire spdbf_pkg::spdbf_bus_t bus,      // register port request
    output logic [31:0] rd_data,                // read data, cycle after read
    input wire logic core_tx_req,               // core transmit dma request pulse
    input wire logic core_rx_req,               // core receive dma request pulse
    input wire logic [31:0] core_rx_data,       // core receive word on offer
    output logic core_rx_rd,                    // take the offered receive word
    output logic [31:0] core_tx_data,           // word to core
    output logic core_tx_valid,                 // core_tx_data valid pulse
    output logic host_tx_req,                   // transmit dma request to host
    output logic host_rx_req                    // receive dma request to host
);
    localparam int unsigned AW = $clog2(DEPTH);
    localparam int unsigned LW = AW + 1;

    typedef enum logic [1:0] {ENG_IDLE, ENG_TX, ENG_RX} spdbf_eng_t;

    function automatic logic fits(input logic [31:0] have, input logic [31:0] need);
        fits = (need != 32'h0000_0000) && (have >= need);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    logic tx_en_ff, rx_en_ff;
    logic [CNT_W-1:0] tx_burst_ff, tx_evt_ff, rx_burst_ff, rx_evt_ff;
    logic [31:0] tx_mem [DEPTH];
    logic [31:0] rx_mem [DEPTH];
    logic [LW-1:0] tx_wp_ff, tx_rp_ff, rx_wp_ff, rx_rp_ff;
    logic [LW-1:0] tx_level, rx_level;
    logic [31:0] tx_free32, rx_free32, tx_lvl32, rx_lvl32;
    logic wr_tx_ctrl, wr_rx_ctrl, wr_tx_data, rd_rx_data, rd_status;
    logic tx_push, rx_pop;
    logic tx_pend_ff, rx_pend_ff, tx_go, rx_go;
    spdbf_eng_t eng_ff;
    logic [CNT_W-1:0] beat_ff;
    logic tx_wait_ff, rx_wait_ff;
    logic [CNT_W-1:0] tx_seen_ff, rx_seen_ff;

    assign wr_tx_ctrl = bus.wr && bus.addr == spdbf_pkg::OFF_TX_CTRL;
    assign wr_rx_ctrl = bus.wr && bus.addr == spdbf_pkg::OFF_RX_CTRL;
    assign wr_tx_data = bus.wr && bus.addr == spdbf_pkg::OFF_TX_DATA;
    assign rd_rx_data = bus.rd && bus.addr == spdbf_pkg::OFF_RX_DATA;
    assign rd_status = bus.rd && bus.addr == spdbf_pkg::OFF_STATUS;

    assign tx_level = tx_wp_ff - tx_rp_ff;
    assign rx_level = rx_wp_ff - rx_rp_ff;
    assign tx_lvl32 = 32'(tx_level);
    assign rx_lvl32 = 32'(rx_level);
    assign tx_free32 = 32'(DEPTH) - tx_lvl32;
    // a receive word taken this cycle lands next edge, so count it as used
    assign rx_free32 = 32'(DEPTH) - rx_lvl32 - 32'(core_rx_rd);
    assign tx_push = tx_en_ff && wr_tx_data && tx_level != LW'(DEPTH);
    assign rx_pop = rx_en_ff && rd_rx_data && rx_level != '0;

    ////////////////////////////////////////////////////////////////////////////
    // control registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_en_ff <= spdbf_pkg::CTRL_RST[0];
            rx_en_ff <= spdbf_pkg::CTRL_RST[0];
            tx_burst_ff <= '0;
            tx_evt_ff <= '0;
            rx_burst_ff <= '0;
            rx_evt_ff <= '0;
        end else begin
            if (wr_tx_ctrl) begin
                tx_en_ff <= bus.wdata[spdbf_pkg::EN_BIT];
                tx_burst_ff <= bus.wdata[spdbf_pkg::BURST_LSB +: CNT_W];
                tx_evt_ff <= bus.wdata[spdbf_pkg::EVT_LSB +: CNT_W];
            end
            if (wr_rx_ctrl) begin
                rx_en_ff <= bus.wdata[spdbf_pkg::EN_BIT];
                rx_burst_ff <= bus.wdata[spdbf_pkg::BURST_LSB +: CNT_W];
                rx_evt_ff <= bus.wdata[spdbf_pkg::EVT_LSB +: CNT_W];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // storage arrays, no reset needed on data
    always_ff @(posedge clk) begin
        if (tx_push) begin
            tx_mem[tx_wp_ff[AW-1:0]] <= bus.wdata;
        end
        if (core_rx_rd && rx_en_ff && eng_ff != ENG_TX) begin
            rx_mem[rx_wp_ff[AW-1:0]] <= core_rx_data;
        end
    end

    // host side pointers, flushed while a fifo is off
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_wp_ff <= '0;
            rx_rp_ff <= '0;
        end else begin
            if (!tx_en_ff) begin
                tx_wp_ff <= '0;
            end else if (tx_push) begin
                tx_wp_ff <= tx_wp_ff + 1'b1;
            end
            if (!rx_en_ff) begin
                rx_rp_ff <= '0;
            end else if (rx_pop) begin
                rx_rp_ff <= rx_rp_ff + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pending core requests; a new request wins over the clear at burst start
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_pend_ff <= 1'b0;
            rx_pend_ff <= 1'b0;
        end else begin
            if (!tx_en_ff) begin
                tx_pend_ff <= 1'b0;
            end else if (core_tx_req) begin
                tx_pend_ff <= 1'b1;
            end else if (eng_ff == ENG_IDLE && tx_go) begin
                tx_pend_ff <= 1'b0;
            end
            if (!rx_en_ff) begin
                rx_pend_ff <= 1'b0;
            end else if (core_rx_req) begin
                rx_pend_ff <= 1'b1;
            end else if (eng_ff == ENG_IDLE && rx_go && !tx_go) begin
                rx_pend_ff <= 1'b0;
            end
        end
    end

    assign tx_go = tx_pend_ff && tx_en_ff
        && fits(tx_lvl32, 32'(tx_burst_ff) << 1);
    assign rx_go = rx_pend_ff && rx_en_ff && fits(rx_free32, 32'(rx_burst_ff));

    ////////////////////////////////////////////////////////////////////////////
    // burst engine toward the core, one word per cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            eng_ff <= ENG_IDLE;
            beat_ff <= '0;
            tx_rp_ff <= '0;
            rx_wp_ff <= '0;
        end else begin
            if (!tx_en_ff) begin
                tx_rp_ff <= '0;
            end else if (eng_ff == ENG_TX) begin
                tx_rp_ff <= tx_rp_ff + 1'b1;
            end
            if (!rx_en_ff) begin
                rx_wp_ff <= '0;
            end else if (core_rx_rd && eng_ff != ENG_TX) begin
                rx_wp_ff <= rx_wp_ff + 1'b1;
            end
            unique case (eng_ff)
                ENG_IDLE: begin
                    // tx_go implies the write fifo is on, so transmit wins ties
                    if (tx_go) begin
                        eng_ff <= ENG_TX;
                        beat_ff <= tx_burst_ff;
                    end else if (rx_go) begin
                        eng_ff <= ENG_RX;
                        beat_ff <= rx_burst_ff;
                    end
                end
                ENG_TX, ENG_RX: begin
                    // no exit other than the last beat
                    beat_ff <= beat_ff - 1'b1;
                    if (beat_ff == CNT_W'(1)) begin
                        eng_ff <= ENG_IDLE;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // core facing outputs; pass-through when a fifo is off
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            core_tx_data <= '0;
            core_tx_valid <= 1'b0;
        end else if (tx_en_ff) begin
            core_tx_valid <= eng_ff == ENG_TX;
            core_tx_data <= tx_mem[tx_rp_ff[AW-1:0]];
        end else begin
            core_tx_valid <= wr_tx_data;
            core_tx_data <= bus.wdata;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            core_rx_rd <= 1'b0;
        end else if (rx_en_ff) begin
            core_rx_rd <= eng_ff == ENG_RX;
        end else begin
            core_rx_rd <= rd_rx_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // host request pacers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            host_tx_req <= 1'b0;
            tx_wait_ff <= 1'b0;
            tx_seen_ff <= '0;
        end else if (!tx_en_ff) begin
            host_tx_req <= core_tx_req;
            tx_wait_ff <= 1'b0;
            tx_seen_ff <= '0;
        end else if (!tx_wait_ff) begin
            // an empty fifo fits at once, so enabling requests next cycle
            host_tx_req <= fits(tx_free32, 32'(tx_evt_ff));
            tx_wait_ff <= fits(tx_free32, 32'(tx_evt_ff));
            tx_seen_ff <= '0;
        end else begin
            host_tx_req <= 1'b0;
            if (wr_tx_data) begin
                tx_seen_ff <= tx_seen_ff + 1'b1;
                tx_wait_ff <= tx_seen_ff + 1'b1 != tx_evt_ff;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            host_rx_req <= 1'b0;
            rx_wait_ff <= 1'b0;
            rx_seen_ff <= '0;
        end else if (!rx_en_ff) begin
            host_rx_req <= core_rx_req;
            rx_wait_ff <= 1'b0;
            rx_seen_ff <= '0;
        end else if (!rx_wait_ff) begin
            host_rx_req <= fits(rx_lvl32, 32'(rx_evt_ff));
            rx_wait_ff <= fits(rx_lvl32, 32'(rx_evt_ff));
            rx_seen_ff <= '0;
        end else begin
            host_rx_req <= 1'b0;
            if (rd_rx_data) begin
                rx_seen_ff <= rx_seen_ff + 1'b1;
                rx_wait_ff <= rx_seen_ff + 1'b1 != rx_evt_ff;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data; pass-through receive read returns the core word directly
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_data <= '0;
        end else begin
            if (bus.rd) begin
                unique case (bus.addr)
                    spdbf_pkg::OFF_TX_CTRL: rd_data <= (32'(tx_evt_ff) << spdbf_pkg::EVT_LSB)
                        | (32'(tx_burst_ff) << spdbf_pkg::BURST_LSB) | 32'(tx_en_ff);
                    spdbf_pkg::OFF_RX_CTRL: rd_data <= (32'(rx_evt_ff) << spdbf_pkg::EVT_LSB)
                        | (32'(rx_burst_ff) << spdbf_pkg::BURST_LSB) | 32'(rx_en_ff);
                    spdbf_pkg::OFF_RX_DATA: begin
                        if (!rx_en_ff) begin
                            rd_data <= core_rx_data;
                        end else if (rx_pop) begin
                            rd_data <= rx_mem[rx_rp_ff[AW-1:0]];
                        end else begin
                            rd_data <= '0;
                        end
                    end
                    spdbf_pkg::OFF_STATUS: rd_data <= (rx_lvl32 << spdbf_pkg::STAT_RX_LSB)
                        | tx_lvl32;
                    default: rd_data <= '0;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

/* File: bench/spdbf_buffer_fifo_monitor.sv */
// Purpose: port-level checker for the buffer fifo
// Assumes: enables and burst counts are shadowed from register writes
// Notes: bound to every instance of the buffer fifo
`timescale 1ns/100ps
`default_nettype none
module spdbf_monitor #(
    parameter int unsigned DEPTH = 16,
    parameter int unsigned CNT_W = 8
) (
    input wire logic clk, // clock
    input wire logic rst, // async reset
    input wire spdbf_pkg::spdbf_bus_t bus, // register port
    input wire logic [31:0] rd_data, // read data
    input wire logic core_tx_req, // core tx request
    input wire logic core_rx_req, // core rx request
    input wire logic [31:0] core_rx_data, // core rx word
    input wire logic core_rx_rd, // core rx take
    input wire logic [31:0] core_tx_data, // core tx word
    input wire logic core_tx_valid, // core tx strobe
    input wire logic host_tx_req, // host tx request
    input wire logic host_rx_req // host rx request
);
    ////////////////////////////////////////
    logic tx_en_ff, rx_en_ff, tx_ctl, rx_ctl;
    logic [CNT_W-1:0] tx_bc_ff, rx_bc_ff, tx_run_ff, rx_run_ff;
    assign tx_ctl = bus.wr && bus.addr == spdbf_pkg::OFF_TX_CTRL;
    assign rx_ctl = bus.wr && bus.addr == spdbf_pkg::OFF_RX_CTRL;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_en_ff <= 1'b0;
            rx_en_ff <= 1'b0;
            tx_bc_ff <= '0;
            rx_bc_ff <= '0;
        end else begin
            if (tx_ctl) begin
                tx_en_ff <= bus.wdata[spdbf_pkg::EN_BIT];
                tx_bc_ff <= bus.wdata[spdbf_pkg::BURST_LSB +: CNT_W];
            end
            if (rx_ctl) begin
                rx_en_ff <= bus.wdata[spdbf_pkg::EN_BIT];
                rx_bc_ff <= bus.wdata[spdbf_pkg::BURST_LSB +: CNT_W];
            end
        end
    end
    // train length is still visible at the edge where the strobe is seen low
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_run_ff <= '0;
            rx_run_ff <= '0;
        end else begin
            tx_run_ff <= core_tx_valid ? tx_run_ff + 1'b1 : '0;
            rx_run_ff <= core_rx_rd ? rx_run_ff + 1'b1 : '0;
        end
    end
    ////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_tx_enable;
        tx_ctl && bus.wdata[spdbf_pkg::EN_BIT] && !tx_en_ff
            && bus.wdata[spdbf_pkg::EVT_LSB +: CNT_W] != 0
            && bus.wdata[spdbf_pkg::EVT_LSB +: CNT_W] <= DEPTH;
    endsequence
    sequence s_tx_end;
        tx_en_ff && $fell(core_tx_valid);
    endsequence
    sequence s_rx_end;
        rx_en_ff && $fell(core_rx_rd);
    endsequence
    a_tx_pass_req: assert property (!tx_en_ff && core_tx_req |=> host_tx_req)
        else $error("core tx request not forwarded");
    a_rx_pass_req: assert property (!rx_en_ff && core_rx_req |=> host_rx_req)
        else $error("core rx request not forwarded");
    a_tx_pass_data: assert property (!tx_en_ff && bus.wr && bus.addr == spdbf_pkg::OFF_TX_DATA
        |=> core_tx_valid && core_tx_data == $past(bus.wdata))
        else $error("tx word not passed through");
    a_rx_pass_read: assert property (!rx_en_ff && bus.rd && bus.addr == spdbf_pkg::OFF_RX_DATA
        |=> core_rx_rd && rd_data == core_rx_data)
        else $error("rx word not passed through");
    a_tx_on_request: assert property (s_tx_enable |-> ##[1:2] host_tx_req)
        else $error("no host tx request after enable");
    a_tx_burst_len: assert property (s_tx_end |-> tx_run_ff == tx_bc_ff)
        else $error("tx burst length wrong");
    a_rx_burst_len: assert property (s_rx_end |-> rx_run_ff == rx_bc_ff)
        else $error("rx burst length wrong");
    a_no_preempt: assert property (tx_en_ff && rx_en_ff && core_tx_valid |-> !core_rx_rd)
        else $error("two bursts overlap");
endmodule
bind spdbf_buffer_fifo spdbf_monitor #(.DEPTH(DEPTH), .CNT_W(CNT_W)) u_mon (
    .clk(clk), .rst(rst), .bus(bus), .rd_data(rd_data), .core_tx_req(core_tx_req),
    .core_rx_req(core_rx_req), .core_rx_data(core_rx_data), .core_rx_rd(core_rx_rd),
    .core_tx_data(core_tx_data), .core_tx_valid(core_tx_valid),
    .host_tx_req(host_tx_req), .host_rx_req(host_rx_req)
);
`default_nettype wire

/* File: bench/spdbf_core_model.sv */
// Purpose: behavioural serial port core facing the buffer fifo
// Assumes: bench commands each request with a one-cycle go pulse
// Notes: rx words count up so loss or reorder shows at once
`timescale 1ns/100ps
`default_nettype none
module spdbf_core_model (
    input wire logic clk, // clock
    input wire logic rst, // async reset
    input wire logic tx_go, // raise tx request
    input wire logic rx_go, // raise rx request
    input wire logic core_tx_valid, // word from fifo
    input wire logic [31:0] core_tx_data, // tx word
    input wire logic core_rx_rd, // fifo took rx word
    output logic core_tx_req, // tx request pulse
    output logic core_rx_req, // rx request pulse
    output logic [31:0] core_rx_data, // rx word on offer
    output logic [15:0] tx_got_ff, // tx words taken
    output logic [31:0] tx_last_ff, // last tx word
    output logic [15:0] rx_idx_ff // rx words given
);
    // requests never depend on the fifo mode
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            core_tx_req <= 1'b0;
            core_rx_req <= 1'b0;
        end else begin
            core_tx_req <= tx_go;
            core_rx_req <= rx_go;
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_got_ff <= '0;
            tx_last_ff <= '0;
            rx_idx_ff <= '0;
        end else begin
            if (core_tx_valid) begin
                tx_got_ff <= tx_got_ff + 1'b1;
                tx_last_ff <= core_tx_data;
            end
            if (core_rx_rd) begin
                rx_idx_ff <= rx_idx_ff + 1'b1;
            end
        end
    end
    assign core_rx_data = 32'hc0de_0000 + {16'h0, rx_idx_ff};
endmodule
`default_nettype wire

/* File: bench/spdbf_buffer_fifo_tb.sv */
// Purpose: self-checking bench of the buffer fifo
// Assumes: core model on the core side, bench on the register port
// Notes: burst 2, event 4 keep every run short
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
module spdbf_buffer_fifo_tb;
    localparam logic [7:0] TXC = spdbf_pkg::OFF_TX_CTRL;
    localparam logic [7:0] RXC = spdbf_pkg::OFF_RX_CTRL;
    localparam logic [7:0] TXD = spdbf_pkg::OFF_TX_DATA;
    localparam logic [7:0] RXD = spdbf_pkg::OFF_RX_DATA;
    localparam logic [31:0] CFG = 32'h0004_0201;
    typedef struct {logic [31:0] w; logic [31:0] r;} spdbf_row_t;
    spdbf_row_t rows [3] = '{'{32'h1234_5678, 32'hc0de_0000}, '{32'hffff_0001, 32'hc0de_0001},
        '{32'h0000_0000, 32'hc0de_0002}};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic tx_go = 1'b0;
    logic rx_go = 1'b0;
    spdbf_pkg::spdbf_bus_t bus = '0;
    logic [31:0] rd_data, core_rx_data, core_tx_data, tx_last, rv;
    logic core_tx_req, core_rx_req, core_rx_rd, core_tx_valid, host_tx_req, host_rx_req;
    logic [15:0] tx_got, rx_idx;
    int error_cnt = 0;
    int cmp_count = 0;
    int cyc, htx, hrx, t_tx, t_rx, b0, b1;
    always #2 clk = ~clk;
    spdbf_buffer_fifo #(.DEPTH(16), .CNT_W(8)) dut (.clk(clk), .rst(rst), .bus(bus),
        .rd_data(rd_data), .core_tx_req(core_tx_req), .core_rx_req(core_rx_req),
        .core_rx_data(core_rx_data), .core_rx_rd(core_rx_rd), .core_tx_data(core_tx_data),
        .core_tx_valid(core_tx_valid), .host_tx_req(host_tx_req), .host_rx_req(host_rx_req));
    spdbf_core_model core (.clk(clk), .rst(rst), .tx_go(tx_go), .rx_go(rx_go),
        .core_tx_valid(core_tx_valid), .core_tx_data(core_tx_data), .core_rx_rd(core_rx_rd),
        .core_tx_req(core_tx_req), .core_rx_req(core_rx_req), .core_rx_data(core_rx_data),
        .tx_got_ff(tx_got), .tx_last_ff(tx_last), .rx_idx_ff(rx_idx));
    ////////////////////////////////////////
    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (host_tx_req === 1'b1) htx++;
        if (host_rx_req === 1'b1) hrx++;
        if (core_tx_valid === 1'b1 && t_tx == 0) t_tx = cyc;
        if (core_rx_rd === 1'b1 && t_rx == 0) t_rx = cyc;
        // far above the few hundred cycles the sequence needs
        if (cyc == 4000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 rv = rd_data;
    endtask
    task automatic req(input logic t, input logic r);
        @(posedge clk);
        tx_go <= t;
        rx_go <= r;
        @(posedge clk);
        tx_go <= 1'b0;
        rx_go <= 1'b0;
        repeat (12) @(posedge clk);
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd(spdbf_pkg::OFF_STATUS);
        `CHK("status", 32'h0, rv)
        rd(8'h14);
        `CHK("unmapped", 32'h0, rv)
        foreach (rows[i]) begin
            wr(TXD, rows[i].w);
            @(posedge clk);
            #1 `CHK("tx pass", rows[i].w, tx_last)
            rd(RXD);
            `CHK("rx pass", rows[i].r, rv)
        end
        b0 = htx;
        b1 = hrx;
        req(1'b1, 1'b1);
        `CHK("htx pass", b0 + 1, htx)
        `CHK("hrx pass", b1 + 1, hrx)
        $display("pass-through done");
        b0 = htx;
        wr(TXC, CFG);
        repeat (8) @(posedge clk);
        `CHK("tx on", b0 + 1, htx)
        for (int i = 0; i < 4; i++) wr(TXD, 32'ha000_0000 + i);
        repeat (8) @(posedge clk);
        `CHK("tx pace", b0 + 2, htx)
        b1 = tx_got;
        req(1'b1, 1'b0);
        `CHK("tx burst", b1 + 2, tx_got)
        `CHK("tx word", 32'ha000_0001, tx_last)
        `CHK("tx absorb", b0 + 2, htx)
        req(1'b1, 1'b0);
        `CHK("tx wait", b1 + 2, tx_got)
        wr(TXD, 32'ha000_0004);
        wr(TXD, 32'ha000_0005);
        repeat (12) @(posedge clk);
        `CHK("tx late", b1 + 4, tx_got)
        `CHK("tx late word", 32'ha000_0003, tx_last)
        for (int i = 0; i < 20; i++) wr(TXD, 32'hb000_0000 + i);
        rd(spdbf_pkg::OFF_STATUS);
        `CHK("tx full", 16'h0010, rv[15:0])
        wr(TXC, 32'h0);
        $display("tx fifo done");
        b0 = hrx;
        b1 = rx_idx;
        wr(RXC, CFG);
        req(1'b0, 1'b1);
        `CHK("rx burst", b1 + 2, rx_idx)
        `CHK("rx absorb", b0, hrx)
        for (int i = 0; i < 3; i++) begin
            rd(RXD);
            `CHK("rx drain", (i < 2) ? 32'hc0de_0000 + b1 + i : 32'h0, rv)
        end
        req(1'b0, 1'b1);
        req(1'b0, 1'b1);
        `CHK("rx event", b0 + 1, hrx)
        for (int i = 0; i < 4; i++) begin
            rd(RXD);
            `CHK("rx data", 32'hc0de_0002 + b1 + i, rv)
        end
        $display("rx fifo done");
        wr(TXC, CFG);
        for (int i = 0; i < 4; i++) wr(TXD, 32'hd000_0000 + i);
        t_tx = 0;
        t_rx = 0;
        req(1'b1, 1'b1);
        `CHK("tx first", 1'b1, t_tx != 0 && t_tx < t_rx)
        wr(TXC, 32'h0);
        t_tx = 0;
        t_rx = 0;
        b0 = htx;
        req(1'b1, 1'b1);
        `CHK("rx only", 1'b1, t_rx != 0 && t_tx == 0)
        `CHK("tx by", b0 + 1, htx)
        $display("arbitration done");
        // a mid-run reset with the write fifo on must fall back to pass-through
        wr(TXC, CFG);
        repeat (4) @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        wr(TXD, 32'he000_0001);
        @(posedge clk);
        #1 `CHK("rst tx off", 32'he000_0001, tx_last)
        rd(RXD);
        `CHK("rst rx off", 32'hc0de_0000, rv)
        $display("reset done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
